// ### hw/press_seq_pkg.sv
package press_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK_PERIOD_MS = 100;
  localparam int TICK_CYCLES = TICK_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TMR_W = 12;
  localparam int PRIOR_ACT_S = 8;
  localparam int AUTO_SHORT_S = 30;
  localparam int AUTO_LONG_MIN = 5;
  localparam int BAR_MAX_SPM = 6;
  localparam int BLINK_HALF_MS = 500;
  localparam logic [TMR_W-1:0] PRIOR_ACT_TICKS =
    TMR_W'(PRIOR_ACT_S * 1000 / TICK_PERIOD_MS);
  localparam logic [TMR_W-1:0] AUTO_SHORT_TICKS =
    TMR_W'(AUTO_SHORT_S * 1000 / TICK_PERIOD_MS);
  localparam logic [TMR_W-1:0] AUTO_LONG_TICKS =
    TMR_W'(AUTO_LONG_MIN * 60 * 1000 / TICK_PERIOD_MS);
  // shortest legal crank revolution while barring
  localparam logic [TMR_W-1:0] BAR_MIN_REV_TICKS =
    TMR_W'(60 * 1000 / (BAR_MAX_SPM * TICK_PERIOD_MS));
  localparam logic [3:0] BLINK_TICKS = 4'(BLINK_HALF_MS / TICK_PERIOD_MS);

  ////////////////////////////////////////////////////////////////////////////
  // selector codes and fault codes
  localparam logic [1:0] STROKE_OFF = 2'h0;
  localparam logic [1:0] STROKE_INCH = 2'h1;
  localparam logic [1:0] STROKE_SINGLE = 2'h2;
  localparam logic [1:0] STROKE_CONTINUOUS_STROKE_SETTING = 2'h3;
  localparam logic [1:0] MODE_TWO_HAND = 2'h0;
  localparam logic [1:0] MODE_ONE_HAND = 2'h1;
  localparam logic [1:0] MODE_FOOT = 2'h2;
  localparam logic [7:0] NO_FAULT_CODE = 8'h00;
  localparam logic [7:0] BAR_OVERSPEED_FAULT_CODE = 8'h1A;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic [1:0] stroke_sel;
    logic [1:0] mode_sel;
    logic auto_sel;
    logic auto_long;
    logic fw_foot;
    logic keyed_sel;
    logic curtain_fitted;
    logic prior_act;
    logic palm_left;
    logic palm_right;
    logic foot;
    logic ext_go;
    logic top_stop;
    logic estop;
    logic sys_fault;
    logic curtain_blocked;
    logic muted;
    logic at_top;
    logic past_bdc;
    logic past_carry;
    logic crank_rev;
    logic motor_off;
    logic bar_select;
    logic bar_operate;
    logic reset_select;
  } pins_s;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ARMED = 8'h02,
    ST_STROKE = 8'h04,
    ST_CARRY = 8'h08,
    ST_AUTO_WAIT = 8'h10,
    ST_INTERRUPT = 8'h20,
    ST_BAR = 8'h40,
    ST_BAR_FAULT = 8'h80
  } seq_state_e;

  typedef enum logic [2:0] {
    RUN_AUTO = 3'h1,
    RUN_TWO = 3'h2,
    RUN_FOOT = 3'h4
  } run_kind_e;

endpackage : press_seq_pkg

// ### hw/pin_sync.sv
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : pin_sync

// ### hw/tick_timer.sv
`timescale 1ns/1ns
module tick_timer #(
  parameter int W = press_seq_pkg::TMR_W
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic tick_in,
  input wire logic load_in,
  input wire logic [W-1:0] load_val_in,
  output logic running_out,
  output logic expired_out
);

  logic [W-1:0] cnt_r;

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_r <= '0;
    end else if (load_in) begin
      cnt_r <= load_val_in;
    end else if (tick_in && cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      expired_out <= 1'b0;
    end else begin
      expired_out <= tick_in && !load_in && cnt_r == W'(1);
    end
  end

  assign running_out = cnt_r != '0;

endmodule : tick_timer

// ### hw/press_stroke_mode_sequencer.sv
// What this block does
// - after top stop, open go window: 30 s, or 5 min with option switch 5 on.
// - no go within the window flags a problem; no next stroke until re-armed.
// - first auto stroke: prior-act (lamp blinks) then palms held past bottom.
// - later auto strokes run alone, pausing at top stop for the go signal.
// - continuous two-hand starts only if palms pressed within 8 s of prior-act.
// - prior-act lamp lights on prior-act press and goes out when 8 s expire.
// - continuous two-hand palms released before carry-up stops ram mid-stroke.
// - continuous two-hand runs until top stop, e-stop, fault or curtain trip.
// - e-stop in continuous gives two-hand maintained recovery, flashing LED.
// - continuous foot starts only if foot pressed within 8 s of prior-act.
// - continuous foot strokes while held; on release finish at top stop.
// - continuous foot also stops on top stop, e-stop, fault, curtain trip.
// - option switch 3 has no effect in continuous foot mode.
// - continuous foot needs foot firmware, keyed selector and light curtain.
// - in bar mode, above 6 strokes per minute stop and show overspeed code.
// - reset/select clears the bar overspeed fault and barring resumes.
`timescale 1ns/1ns
module press_stroke_mode_sequencer #(
  parameter int TICK_CYCLES = press_seq_pkg::TICK_CYCLES
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [1:0] stroke_sel_in,
  input wire logic [1:0] mode_sel_in,
  input wire logic auto_sel_in,
  input wire logic opt_auto_long_in,
  input wire logic fw_foot_in,
  input wire logic keyed_sel_in,
  input wire logic curtain_fitted_in,
  input wire logic prior_act_btn_in,
  input wire logic palm_left_in,
  input wire logic palm_right_in,
  input wire logic foot_sw_in,
  input wire logic ext_go_in,
  input wire logic top_stop_btn_in,
  input wire logic estop_in,
  input wire logic sys_fault_in,
  input wire logic curtain_blocked_in,
  input wire logic curtain_muted_in,
  input wire logic at_top_in,
  input wire logic past_bdc_in,
  input wire logic past_carry_up_in,
  input wire logic crank_rev_in,
  input wire logic motor_off_in,
  input wire logic bar_select_in,
  input wire logic bar_operate_in,
  input wire logic reset_select_in,
  output logic clutch_out,
  output logic prior_act_lamp_out,
  output logic interrupted_led_out,
  output logic auto_problem_out,
  output logic bar_mode_out,
  output logic [7:0] fault_code_out
);

  localparam int DIV_W = $clog2(TICK_CYCLES + 1);

  press_seq_pkg::pins_s raw;
  press_seq_pkg::pins_s p;
  press_seq_pkg::seq_state_e state_r;
  press_seq_pkg::seq_state_e state_nxt;
  press_seq_pkg::run_kind_e kind_r;
  press_seq_pkg::run_kind_e kind_nxt;

  logic [DIV_W-1:0] div_r;
  logic tick_r;
  logic [3:0] blink_cnt_r;
  logic blink_r;
  logic [5:0] prev_r;
  logic prior_rise;
  logic go_rise;
  logic operate_rise;
  logic reset_rise;
  logic top_rise;
  logic crank_rise;
  logic both_palms;
  logic auto_ok;
  logic two_ok;
  logic foot_ok;
  logic bar_ok;
  logic kind_ok;
  logic halt;
  logic finish_r;
  logic problem_r;
  logic tmr_load;
  logic [press_seq_pkg::TMR_W-1:0] tmr_val;
  logic tmr_running;
  logic tmr_expired;
  logic rev_load;
  logic [press_seq_pkg::TMR_W-1:0] rev_val;
  logic rev_running;
  logic overspeed;

  ////////////////////////////////////////////////////////////////////////////
  // pin capture
  always_comb begin
    raw = '0;
    raw.stroke_sel = stroke_sel_in;
    raw.mode_sel = mode_sel_in;
    raw.auto_sel = auto_sel_in;
    raw.auto_long = opt_auto_long_in;
    raw.fw_foot = fw_foot_in;
    raw.keyed_sel = keyed_sel_in;
    raw.curtain_fitted = curtain_fitted_in;
    raw.prior_act = prior_act_btn_in;
    raw.palm_left = palm_left_in;
    raw.palm_right = palm_right_in;
    raw.foot = foot_sw_in;
    raw.ext_go = ext_go_in;
    raw.top_stop = top_stop_btn_in;
    raw.estop = estop_in;
    raw.sys_fault = sys_fault_in;
    raw.curtain_blocked = curtain_blocked_in;
    raw.muted = curtain_muted_in;
    raw.at_top = at_top_in;
    raw.past_bdc = past_bdc_in;
    raw.past_carry = past_carry_up_in;
    raw.crank_rev = crank_rev_in;
    raw.motor_off = motor_off_in;
    raw.bar_select = bar_select_in;
    raw.bar_operate = bar_operate_in;
    raw.reset_select = reset_select_in;
  end

  pin_sync #(
    .W($bits(press_seq_pkg::pins_s))
  ) u_sync (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .async_in(raw),
    .sync_out(p)
  );

  ////////////////////////////////////////////////////////////////////////////
  // system tick and lamp blink
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      div_r <= '0;
      tick_r <= 1'b0;
    end else if (div_r == DIV_W'(TICK_CYCLES - 1)) begin
      div_r <= '0;
      tick_r <= 1'b1;
    end else begin
      div_r <= div_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      blink_cnt_r <= '0;
      blink_r <= 1'b0;
    end else if (tick_r) begin
      if (blink_cnt_r >= press_seq_pkg::BLINK_TICKS - 4'h1) begin
        blink_cnt_r <= '0;
        blink_r <= ~blink_r;
      end else begin
        blink_cnt_r <= blink_cnt_r + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // edges and qualifiers
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prev_r <= '0;
    end else begin
      prev_r <= {p.prior_act, p.ext_go, p.bar_operate,
                 p.reset_select, p.at_top, p.crank_rev};
    end
  end

  assign prior_rise = p.prior_act & ~prev_r[5];
  assign go_rise = p.ext_go & ~prev_r[4];
  assign operate_rise = p.bar_operate & ~prev_r[3];
  assign reset_rise = p.reset_select & ~prev_r[2];
  assign top_rise = p.at_top & ~prev_r[1];
  assign crank_rise = p.crank_rev & ~prev_r[0];
  assign both_palms = p.palm_left & p.palm_right;

  assign auto_ok = p.stroke_sel == press_seq_pkg::STROKE_SINGLE &&
                   p.mode_sel == press_seq_pkg::MODE_TWO_HAND && p.auto_sel;
  assign two_ok = p.stroke_sel == press_seq_pkg::STROKE_CONTINUOUS_STROKE_SETTING &&
                  p.mode_sel == press_seq_pkg::MODE_TWO_HAND;
  // foot running is refused unless the installation can guard it
  assign foot_ok = p.stroke_sel == press_seq_pkg::STROKE_CONTINUOUS_STROKE_SETTING &&
                   p.mode_sel == press_seq_pkg::MODE_FOOT &&
                   p.fw_foot && p.keyed_sel && p.curtain_fitted;
  assign bar_ok = p.stroke_sel == press_seq_pkg::STROKE_INCH &&
                  p.mode_sel == press_seq_pkg::MODE_TWO_HAND &&
                  p.motor_off && p.bar_select;

  always_comb begin
    unique case (kind_r)
      press_seq_pkg::RUN_AUTO: kind_ok = auto_ok;
      press_seq_pkg::RUN_TWO: kind_ok = two_ok;
      press_seq_pkg::RUN_FOOT: kind_ok = foot_ok;
      default: kind_ok = 1'b0;
    endcase
  end

  // a blocked curtain only counts outside the muted part of the stroke
  assign halt = p.estop | p.sys_fault | (p.curtain_blocked & ~p.muted);

  ////////////////////////////////////////////////////////////////////////////
  // shared window timer: arming interval, then the go window
  tick_timer #(
    .W(press_seq_pkg::TMR_W)
  ) u_win_tmr (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .tick_in(tick_r),
    .load_in(tmr_load),
    .load_val_in(tmr_val),
    .running_out(tmr_running),
    .expired_out(tmr_expired)
  );

  // revolution timer: a new revolution while it still runs is too fast
  assign rev_load = state_r != press_seq_pkg::ST_BAR || crank_rise;
  assign rev_val = state_r == press_seq_pkg::ST_BAR ?
                   press_seq_pkg::BAR_MIN_REV_TICKS : '0;
  assign overspeed = crank_rise && rev_running;

  tick_timer #(
    .W(press_seq_pkg::TMR_W)
  ) u_rev_tmr (
    .clock_in(clock_in),
    .rst_b_in(rst_b_in),
    .tick_in(tick_r),
    .load_in(rev_load),
    .load_val_in(rev_val),
    .running_out(rev_running),
    .expired_out()
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    tmr_load = 1'b0;
    tmr_val = press_seq_pkg::PRIOR_ACT_TICKS;
    unique case (state_r)
      press_seq_pkg::ST_IDLE: begin
        if (bar_ok && operate_rise && !halt) begin
          state_nxt = press_seq_pkg::ST_BAR;
        end else if (prior_rise && (auto_ok || two_ok || foot_ok)) begin
          state_nxt = press_seq_pkg::ST_ARMED;
          tmr_load = 1'b1;
          if (auto_ok) begin
            kind_nxt = press_seq_pkg::RUN_AUTO;
          end else if (two_ok) begin
            kind_nxt = press_seq_pkg::RUN_TWO;
          end else begin
            kind_nxt = press_seq_pkg::RUN_FOOT;
          end
        end
      end
      press_seq_pkg::ST_ARMED: begin
        if (halt || !kind_ok || tmr_expired || !tmr_running) begin
          state_nxt = press_seq_pkg::ST_IDLE;
        end else if (kind_r == press_seq_pkg::RUN_FOOT) begin
          // option switch 3 is never consulted here
          if (p.foot) begin
            state_nxt = press_seq_pkg::ST_STROKE;
          end
        end else if (both_palms) begin
          state_nxt = press_seq_pkg::ST_STROKE;
        end
      end
      press_seq_pkg::ST_STROKE: begin
        if (p.estop && kind_r != press_seq_pkg::RUN_AUTO) begin
          state_nxt = press_seq_pkg::ST_INTERRUPT;
        end else if (halt) begin
          state_nxt = press_seq_pkg::ST_IDLE;
        end else if (kind_r == press_seq_pkg::RUN_FOOT) begin
          state_nxt = press_seq_pkg::ST_CARRY;
        end else if (!both_palms) begin
          state_nxt = press_seq_pkg::ST_IDLE;
        end else if (kind_r == press_seq_pkg::RUN_AUTO ? p.past_bdc : p.past_carry) begin
          state_nxt = press_seq_pkg::ST_CARRY;
        end
      end
      press_seq_pkg::ST_CARRY: begin
        if (p.estop && kind_r != press_seq_pkg::RUN_AUTO) begin
          state_nxt = press_seq_pkg::ST_INTERRUPT;
        end else if (halt) begin
          state_nxt = press_seq_pkg::ST_IDLE;
        end else if (top_rise) begin
          if (finish_r || !kind_ok) begin
            state_nxt = press_seq_pkg::ST_IDLE;
          end else if (kind_r == press_seq_pkg::RUN_AUTO) begin
            state_nxt = press_seq_pkg::ST_AUTO_WAIT;
            tmr_load = 1'b1;
            tmr_val = p.auto_long ? press_seq_pkg::AUTO_LONG_TICKS :
                      press_seq_pkg::AUTO_SHORT_TICKS;
          end
        end
      end
      press_seq_pkg::ST_AUTO_WAIT: begin
        if (halt || !auto_ok || p.top_stop) begin
          state_nxt = press_seq_pkg::ST_IDLE;
        end else if (go_rise) begin
          state_nxt = press_seq_pkg::ST_CARRY;
        end else if (tmr_expired) begin
          state_nxt = press_seq_pkg::ST_IDLE;
        end
      end
      press_seq_pkg::ST_INTERRUPT: begin
        if (top_rise && both_palms) begin
          state_nxt = press_seq_pkg::ST_IDLE;
        end
      end
      press_seq_pkg::ST_BAR: begin
        if (!bar_ok || halt) begin
          state_nxt = press_seq_pkg::ST_IDLE;
        end else if (overspeed) begin
          state_nxt = press_seq_pkg::ST_BAR_FAULT;
        end
      end
      press_seq_pkg::ST_BAR_FAULT: begin
        // the fault holds until acknowledged, whatever the selectors do
        if (reset_rise) begin
          state_nxt = bar_ok ? press_seq_pkg::ST_BAR : press_seq_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = press_seq_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r <= press_seq_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      kind_r <= press_seq_pkg::RUN_AUTO;
    end else begin
      kind_r <= kind_nxt;
    end
  end

  // stop request taken mid-stroke is honoured at the next top stop
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      finish_r <= 1'b0;
    end else if (state_r == press_seq_pkg::ST_ARMED) begin
      finish_r <= 1'b0;
    end else if ((state_r == press_seq_pkg::ST_CARRY ||
                  state_r == press_seq_pkg::ST_STROKE) &&
                 (p.top_stop || (kind_r == press_seq_pkg::RUN_FOOT && !p.foot))) begin
      finish_r <= 1'b1;
    end
  end

  // problem stays up until the operator re-arms with prior-act
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      problem_r <= 1'b0;
    end else if (state_r == press_seq_pkg::ST_AUTO_WAIT &&
                 state_nxt == press_seq_pkg::ST_IDLE && tmr_expired) begin
      problem_r <= 1'b1;
    end else if (state_r == press_seq_pkg::ST_IDLE && prior_rise) begin
      problem_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      clutch_out <= 1'b0;
    end else begin
      unique case (state_nxt)
        press_seq_pkg::ST_STROKE,
        press_seq_pkg::ST_CARRY,
        press_seq_pkg::ST_BAR: clutch_out <= 1'b1;
        press_seq_pkg::ST_INTERRUPT: clutch_out <= both_palms && !halt;
        default: clutch_out <= 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      prior_act_lamp_out <= 1'b0;
    end else if (state_nxt == press_seq_pkg::ST_ARMED) begin
      prior_act_lamp_out <= kind_nxt == press_seq_pkg::RUN_AUTO ? blink_r : 1'b1;
    end else begin
      prior_act_lamp_out <= 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      interrupted_led_out <= 1'b0;
    end else begin
      interrupted_led_out <= state_nxt == press_seq_pkg::ST_INTERRUPT && blink_r;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fault_code_out <= press_seq_pkg::NO_FAULT_CODE;
    end else if (state_nxt == press_seq_pkg::ST_BAR_FAULT) begin
      fault_code_out <= press_seq_pkg::BAR_OVERSPEED_FAULT_CODE;
    end else begin
      fault_code_out <= press_seq_pkg::NO_FAULT_CODE;
    end
  end

  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      bar_mode_out <= 1'b0;
    end else begin
      bar_mode_out <= state_nxt == press_seq_pkg::ST_BAR ||
                      state_nxt == press_seq_pkg::ST_BAR_FAULT;
    end
  end

  assign auto_problem_out = problem_r;

endmodule : press_stroke_mode_sequencer

// ### tb/press_seq_chk.sv
`timescale 1ns/1ns
module press_seq_chk #(
  parameter int TICK_CYCLES = press_seq_pkg::TICK_CYCLES
) (
  input wire logic clock_in,
  input wire logic rst_b_in,
  input wire logic [1:0] stroke_sel_in,
  input wire logic [1:0] mode_sel_in,
  input wire logic palm_left_in,
  input wire logic palm_right_in,
  input wire logic foot_sw_in,
  input wire logic estop_in,
  input wire logic sys_fault_in,
  input wire logic bar_select_in,
  input wire logic reset_select_in,
  input wire logic clutch_out,
  input wire logic prior_act_lamp_out,
  input wire logic auto_problem_out,
  input wire logic bar_mode_out,
  input wire logic [7:0] fault_code_out
);
  // lamp may outlive the window by the tick phase plus the pipeline
  localparam int LAMP_MAX = press_seq_pkg::PRIOR_ACT_TICKS * TICK_CYCLES + 8;
  logic [31:0] lamp_cnt_r;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      lamp_cnt_r <= 32'h00000000;
    end else if (prior_act_lamp_out) begin
      lamp_cnt_r <= lamp_cnt_r + 32'h00000001;
    end else begin
      lamp_cnt_r <= 32'h00000000;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_halt_drops_clutch: assert property ((estop_in || sys_fault_in) [*4] |-> !clutch_out)
    else $error("clutch engaged during halt");
  a_lamp_arm_limit: assert property (lamp_cnt_r <= 32'(LAMP_MAX))
    else $error("prior act lamp lit too long");
  a_continuous_stroke_setting_palms_start: assert property ($rose(clutch_out) &&
    stroke_sel_in == press_seq_pkg::STROKE_CONTINUOUS_STROKE_SETTING && mode_sel_in == press_seq_pkg::MODE_TWO_HAND
    |-> palm_left_in && palm_right_in) else $error("continuous start without palms");
  a_foot_start: assert property ($rose(clutch_out) &&
    mode_sel_in == press_seq_pkg::MODE_FOOT |-> foot_sw_in || (palm_left_in && palm_right_in))
    else $error("foot start without foot");
  a_problem_blocks: assert property (auto_problem_out |-> !clutch_out)
    else $error("stroke while go window missed");
  a_overspeed_stop: assert property (fault_code_out != press_seq_pkg::NO_FAULT_CODE |->
    fault_code_out == press_seq_pkg::BAR_OVERSPEED_FAULT_CODE && !clutch_out && bar_mode_out)
    else $error("fault code without bar stop");
  a_fault_reset_clear: assert property ((fault_code_out != 8'h00 && !reset_select_in)
    ##1 reset_select_in [*6] |-> fault_code_out == 8'h00) else $error("fault not cleared");
  a_bar_needs_select: assert property ((!bar_select_in) [*6] |-> !bar_mode_out)
    else $error("bar mode without select");
endmodule : press_seq_chk
bind press_stroke_mode_sequencer press_seq_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_i (.*);

// ### tb/press_plant.sv
`timescale 1ns/1ns
module press_plant (
  input wire logic clock_in,
  input wire logic clutch_in,
  input wire logic slow_in,
  output logic at_top_out,
  output logic past_bdc_out,
  output logic past_carry_out,
  output logic muted_out
);
  // 256 crank steps a turn; three extra bits let a barred crank turn slowly
  logic [10:0] pos_r = 11'h000;
  logic [7:0] angle;
  assign angle = pos_r[10:3];
  // the brake holds the crank wherever the clutch drops
  always_ff @(posedge clock_in) begin
    if (clutch_in) begin
      pos_r <= pos_r + (slow_in ? 11'h001 : 11'h008);
    end
  end
  assign at_top_out = angle < 8'h10;
  assign past_bdc_out = angle >= 8'h80;
  assign past_carry_out = angle >= 8'hC0;
  assign muted_out = past_bdc_out;
endmodule : press_plant

// ### tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  localparam int TC = 10;
  logic clock_in, rst_b_in, clutch_out, prior_act_lamp_out, interrupted_led_out;
  logic auto_problem_out, bar_mode_out, at_top_in, past_bdc_in, past_carry_up_in;
  logic curtain_muted_in, crank_rev_in;
  logic [7:0] fault_code_out, v;
  bit [1:0] stroke_sel_in, mode_sel_in;
  bit auto_sel_in, opt_auto_long_in, fw_foot_in, keyed_sel_in, curtain_fitted_in, slow;
  bit prior_act_btn_in, palm_left_in, palm_right_in, foot_sw_in, ext_go_in, top_stop_btn_in;
  bit estop_in, sys_fault_in, curtain_blocked_in, motor_off_in, bar_select_in;
  bit bar_operate_in, reset_select_in;
  int bad_count, check_count;
  int seed = 32'h901c95c2;
  press_stroke_mode_sequencer #(.TICK_CYCLES(TC)) DUT (.*);
  press_plant plant (.clock_in(clock_in), .clutch_in(clutch_out), .slow_in(slow),
    .at_top_out(at_top_in), .past_bdc_out(past_bdc_in), .past_carry_out(past_carry_up_in),
    .muted_out(curtain_muted_in));
  assign crank_rev_in = at_top_in;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  function automatic logic [7:0] foot_exp(input int f);
    return 8'(f != 0);
  endfunction : foot_exp
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #10;
  endtask : cyc
  task automatic wt(ref logic s, input logic e);
    for (int i = 0; i < 3000 && s !== e; i++) begin
      cyc(1);
    end
  endtask : wt
  // buttons are held past the synchronisers and the edge detector
  task automatic pulse(ref bit s);
    s = 1'b1;
    cyc(6);
    s = 1'b0;
    cyc(4);
  endtask : pulse
  task automatic hands(input bit e);
    palm_left_in = e;
    palm_right_in = e;
  endtask : hands
  task automatic blink(ref logic s, output logic [7:0] r);
    r = 8'h00;
    repeat (120) begin
      cyc(1);
      r = r | (s === 1'b1 ? 8'h02 : 8'h01);
    end
  endtask : blink
  task automatic stop_test();
    if (bad_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  initial begin
    repeat (60000) @(posedge clock_in);
    bad_count++;
    stop_test();
  end
  initial begin
    rst_b_in = 1'b0;
    cyc(4);
    rst_b_in = 1'b1;
    chk("clutch_reset", 8'h00, 8'(clutch_out));
    stroke_sel_in = press_seq_pkg::STROKE_CONTINUOUS_STROKE_SETTING;
    mode_sel_in = press_seq_pkg::MODE_TWO_HAND;
    cyc(5);
    for (int c = 0; c < 4; c++) begin
      pulse(prior_act_btn_in);
      chk("lamp_on", 8'h01, 8'(prior_act_lamp_out));
      cyc({$random(seed)} % 600);
      hands(1'b1);
      cyc(8);
      chk("clutch_start", 8'h01, 8'(clutch_out));
      cyc(250);
      hands(1'b0);
      cyc(300);
      chk("clutch_run", 8'h01, 8'(clutch_out));
      // causes are applied on the downstroke, where the curtain is live
      wt(curtain_muted_in, 1'b0);
      {top_stop_btn_in, estop_in, sys_fault_in, curtain_blocked_in} = 4'h8 >> c;
      cyc(c == 0 ? 300 : 8);
      {top_stop_btn_in, estop_in, sys_fault_in, curtain_blocked_in} = 4'h0;
      chk("halt", 8'h00, 8'(clutch_out));
      if (c == 1) begin
        blink(interrupted_led_out, v);
        chk("led_blink", 8'h03, v);
        hands(1'b1);
        cyc(8);
        chk("recover", 8'h01, 8'(clutch_out));
        wt(clutch_out, 1'b0);
        cyc(4);
        chk("led_off", 8'h00, 8'(interrupted_led_out));
        hands(1'b0);
      end
    end
    pulse(prior_act_btn_in);
    cyc(760);
    chk("lamp_held", 8'h01, 8'(prior_act_lamp_out));
    cyc(50);
    chk("lamp_out", 8'h00, 8'(prior_act_lamp_out));
    hands(1'b1);
    cyc(10);
    chk("late_palms", 8'h00, 8'(clutch_out));
    hands(1'b0);
    pulse(prior_act_btn_in);
    hands(1'b1);
    cyc(40);
    hands(1'b0);
    cyc(8);
    chk("mid_stop", 8'h00, 8'(clutch_out));
    mode_sel_in = press_seq_pkg::MODE_FOOT;
    fw_foot_in = 1'b1;
    keyed_sel_in = 1'b1;
    for (int f = 0; f < 3; f++) begin
      curtain_fitted_in = (f != 0);
      cyc(5);
      pulse(prior_act_btn_in);
      foot_sw_in = 1'b1;
      cyc(400);
      chk("foot_run", foot_exp(f), 8'(clutch_out));
      if (f == 2) begin
        pulse(top_stop_btn_in);
      end
      foot_sw_in = (f == 2);
      cyc(300);
      chk("foot_top", foot_exp(f), 8'(at_top_in));
      chk("foot_stop", 8'h00, 8'(clutch_out));
      foot_sw_in = 1'b0;
    end
    stroke_sel_in = press_seq_pkg::STROKE_SINGLE;
    mode_sel_in = press_seq_pkg::MODE_TWO_HAND;
    auto_sel_in = 1'b1;
    for (int w = 0; w < 2; w++) begin
      opt_auto_long_in = w[0];
      cyc(5);
      pulse(prior_act_btn_in);
      chk("problem_clear", 8'h00, 8'(auto_problem_out));
      blink(prior_act_lamp_out, v);
      chk("lamp_blink", 8'h03, v);
      hands(1'b1);
      wt(past_bdc_in, 1'b1);
      cyc(4);
      hands(1'b0);
      wt(clutch_out, 1'b0);
      chk("auto_top", 8'h01, 8'(at_top_in));
      cyc(w == 1 ? 3100 : 2900);
      chk("window_open", 8'h00, 8'(auto_problem_out));
      pulse(ext_go_in);
      chk("go_stroke", 8'h01, 8'(clutch_out));
      wt(clutch_out, 1'b0);
      if (w == 0) begin
        cyc(3100);
        chk("window_shut", 8'h01, 8'(auto_problem_out));
        pulse(ext_go_in);
        chk("no_go", 8'h00, 8'(clutch_out));
      end else begin
        pulse(top_stop_btn_in);
      end
    end
    auto_sel_in = 1'b0;
    stroke_sel_in = press_seq_pkg::STROKE_INCH;
    motor_off_in = 1'b1;
    bar_select_in = 1'b1;
    slow = 1'b1;
    cyc(5);
    pulse(bar_operate_in);
    chk("bar_mode", 8'h01, 8'(bar_mode_out));
    cyc(5000);
    chk("bar_slow", 8'h00, fault_code_out);
    slow = 1'b0;
    cyc(1200);
    chk("bar_fast", press_seq_pkg::BAR_OVERSPEED_FAULT_CODE, fault_code_out);
    chk("bar_stopped", 8'h00, 8'(clutch_out));
    pulse(reset_select_in);
    chk("fault_clear", 8'h00, fault_code_out);
    chk("bar_resume", 8'h01, 8'(clutch_out));
    bar_select_in = 1'b0;
    cyc(8);
    chk("bar_left", 8'h00, 8'(bar_mode_out));
    stop_test();
  end
endmodule : tb_top
